// *** rtl/tcg_div.sv ***
// Event divider: one output tick per N input ticks, with a near-square level.
// Assumes input ticks are single-cycle pulses on the system clock.
module tcg_div (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Input events and divisor
    input wire logic i_tick,
    input wire logic [8:0] i_div,
    // Divided events
    output logic o_tick,
    output logic o_level
);

    tcg_pkg::tcg_div_t s_r;
    tcg_pkg::tcg_div_t s_nxt;
    logic [8:0] half;

    always_comb begin
        half = 9'((i_div + 9'h001) >> 1);
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (i_tick) begin
            if (s_r.cnt >= 9'(i_div - 9'h001)) begin
                s_nxt.cnt = 9'h000;
                s_nxt.tick = 1'b1;
            end else begin
                s_nxt.cnt = 9'(s_r.cnt + 9'h001);
            end
        end
        s_nxt.level = (s_nxt.cnt < half);
        if (i_rst) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        s_r <= s_nxt;
    end

    assign o_tick = s_r.tick;
    assign o_level = s_r.level;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_div_wrap;
        @(posedge i_clk) disable iff (i_rst)
        (i_tick && s_r.cnt >= 9'(i_div - 9'h001)) |=> (o_tick && s_r.cnt == 9'h000);
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap"); // [RULE10]

endmodule

// *** rtl/tcg_pkg.sv ***
// Constants and types shared by the clock generator control block.
// Assumes a single system clock and a synchronous, active-high reset.
package tcg_pkg;

    // ------------------------------------------------------------
    // Register map (word indices; byte address = 4 * index)
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_BIT_CLK = 16'hd080;
    localparam logic [15:0] IDX_FRAME_SYNC = 16'hd081;
    localparam logic [15:0] IDX_GEN_CLK = 16'hd082;
    localparam logic [15:0] IDX_REF_SEL = 16'hd083;
    localparam logic [15:0] IDX_REF_PIN = 16'hd084;

    // ------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------
    localparam logic [15:0] RST_BIT_CLK = 16'h0000;
    localparam logic [15:0] RST_FRAME_SYNC = 16'h0001;
    localparam logic [15:0] RST_GEN_CLK = 16'h0008;
    localparam logic [15:0] RST_REF_SEL = 16'h0000;
    localparam logic [15:0] RST_REF_PIN = 16'h0003;
    localparam int EN_BIT = 3;
    localparam logic [2:0] GEN_CLK_MAX = 3'h4;
    localparam logic [2:0] REF_SEL_MAX = 3'h5;
    localparam logic [2:0] REF_DIV_MAX = 3'h4;

    // ------------------------------------------------------------
    // Reference source codes and divisors
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_ALT_192 = 3'h0;
    localparam logic [2:0] SEL_EXT_256 = 3'h1;
    localparam logic [2:0] SEL_EXT = 3'h2;
    localparam logic [2:0] SEL_PIN = 3'h3;
    localparam logic [2:0] SEL_PIN_64 = 3'h4;
    localparam logic [2:0] SEL_FS = 3'h5;
    localparam logic [2:0] REF_DIV_1 = 3'h4;
    localparam logic [8:0] DIV_192 = 9'h0c0;
    localparam logic [8:0] DIV_256 = 9'h100;
    localparam logic [8:0] DIV_64 = 9'h040;
    localparam logic [8:0] DIV_4 = 9'h004;
    localparam logic [8:0] DIV_3 = 9'h003;
    localparam logic [8:0] DIV_1 = 9'h001;

    // ------------------------------------------------------------
    // Bus answers and synchroniser lanes
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int SYN_W = 5;
    localparam int SYN_EXT = 0;
    localparam int SYN_ALT = 1;
    localparam int SYN_PIN = 2;
    localparam int SYN_FS = 3;
    localparam int SYN_STRAP = 4;

    typedef struct packed {
        logic [1:0] bit_clk_rate;
        logic fs_rate;
        logic gen_clk_en;
        logic [2:0] gen_clk_rate;
        logic ref_en;
        logic [2:0] ref_sel;
        logic ref_pin_oe;
        logic [2:0] ref_pin_div;
    } tcg_regs_t;

    localparam tcg_regs_t REGS_RESET = '{
        bit_clk_rate: RST_BIT_CLK[1:0],
        fs_rate: RST_FRAME_SYNC[0],
        gen_clk_en: RST_GEN_CLK[EN_BIT],
        gen_clk_rate: RST_GEN_CLK[2:0],
        ref_en: RST_REF_SEL[EN_BIT],
        ref_sel: RST_REF_SEL[2:0],
        ref_pin_oe: RST_REF_PIN[EN_BIT],
        ref_pin_div: RST_REF_PIN[2:0]
    };

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tcg_axi_t;

    typedef struct packed {
        tcg_regs_t regs;
        tcg_axi_t axi;
        logic master;
        logic ref_tick;
        logic ref_pin_out;
    } tcg_state_t;

    typedef struct packed {
        logic [8:0] cnt;
        logic tick;
        logic level;
    } tcg_div_t;

endpackage

// *** rtl/tcg_sync.sv ***
// Two-flop synchronisers for pin inputs, plus rising-edge detection.
// Assumes the pins are asynchronous to the system clock.
module tcg_sync (
    // Clock
    input wire logic i_clk,
    // Pins
    input wire logic [tcg_pkg::SYN_W-1:0] i_pins,
    // Synchronised levels and rising edges
    output logic [tcg_pkg::SYN_W-1:0] o_level,
    output logic [tcg_pkg::SYN_W-1:0] o_rise
);

    logic [tcg_pkg::SYN_W-1:0] meta_r;
    logic [tcg_pkg::SYN_W-1:0] sync_r;
    logic [tcg_pkg::SYN_W-1:0] last_r;

    // No reset: the strap must pass through while reset is held
    always_ff @(posedge i_clk) begin
        meta_r <= i_pins;
        sync_r <= meta_r;
        last_r <= sync_r;
    end

    assign o_level = sync_r;
    assign o_rise = sync_r & ~last_r;

endmodule

// *** rtl/tcg_top.sv ***
// Clock generator control: AXI4-Lite registers steering PCM clock rates,
// the general clock output pin, the oscillator reference and the reference pin.
// Assumes one 25 MHz system clock; all pins are asynchronous to it.
//
// What this block does
// RULE1: Bit clock rate code 0..3 selects 2.048 to 16.384 MHz, master only.
// RULE2: Frame sync rate bit picks 4 or 8 kHz input, slave only.
// RULE3: Software keeps frame sync rate bit at 1; output is always 8 kHz.
// RULE4: Frame sync and bit clock direction latched from strap during reset.
// RULE5: General clock output enable bit tri-states pin at 0, drives at 1.
// RULE6: General clock rate code 0..4 selects 2.048 to 16.384 MHz.
// RULE7: Oscillator reference enable bit gates the 8 kHz reference.
// RULE8: Reference select picks one of six divided or direct sources.
// RULE9: Reference pin output enable: 0 input with driver off, 1 output.
// RULE10: Reference pin output is external sync clock divided by 256,192,4,3,1.
// RULE11: External sync clock into the reference divider stays below 2.048 MHz.
// RULE12: Unused register bits read as zero.
// RULE13: Unlisted field codes are ignored and the old setting stays.
//
// Added by the designer: the AXI4-Lite slave port.
module tcg_top (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_SYS_RST,
    // AXI4-Lite write channels
    input wire logic [tcg_pkg::ADDR_W-1:0] I_AXI_AWADDR,
    input wire logic I_AXI_AWVALID,
    output logic O_AXI_AWREADY,
    input wire logic [31:0] I_AXI_WDATA,
    input wire logic [3:0] I_AXI_WSTRB,
    input wire logic I_AXI_WVALID,
    output logic O_AXI_WREADY,
    output logic [1:0] O_AXI_BRESP,
    output logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    // AXI4-Lite read channels
    input wire logic [tcg_pkg::ADDR_W-1:0] I_AXI_ARADDR,
    input wire logic I_AXI_ARVALID,
    output logic O_AXI_ARREADY,
    output logic [31:0] O_AXI_RDATA,
    output logic [1:0] O_AXI_RRESP,
    output logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY,
    // Pin inputs
    input wire logic I_MASTER_SLAVE_STRAP,
    input wire logic I_EXTERNAL_SYNC_CLOCK,
    input wire logic I_EXTERNAL_SYNC_CLOCK_ALT,
    input wire logic I_REFERENCE_PIN,
    input wire logic I_PCM_FRAME_SYNC,
    // PCM pin control
    output logic [1:0] O_PCM_BIT_CLOCK_RATE,
    output logic O_PCM_BIT_CLOCK_OE,
    output logic O_PCM_FRAME_SYNC_OE,
    output logic O_PCM_FRAME_SYNC_8K,
    // General clock output control
    output logic [2:0] O_GENERAL_CLOCK_OUTPUT_RATE,
    output logic O_GENERAL_CLOCK_OUTPUT_OE,
    // Oscillator reference and reference pin
    output logic O_OSC_REF_TICK,
    output logic O_REFERENCE_PIN,
    output logic O_REFERENCE_PIN_OE
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] word_index(input logic [tcg_pkg::ADDR_W-1:0] addr);
        word_index = addr[tcg_pkg::ADDR_W-1:2];
    endfunction

    function automatic logic is_mapped(input logic [15:0] idx);
        is_mapped = (idx >= tcg_pkg::IDX_BIT_CLK) && (idx <= tcg_pkg::IDX_REF_PIN);
    endfunction

    function automatic logic [15:0] reg_read(input tcg_pkg::tcg_regs_t r, input logic [15:0] idx);
        reg_read = 16'h0000;
        unique case (idx)
            tcg_pkg::IDX_BIT_CLK: reg_read = {14'h0, r.bit_clk_rate};
            tcg_pkg::IDX_FRAME_SYNC: reg_read = {15'h0, r.fs_rate};
            tcg_pkg::IDX_GEN_CLK: reg_read = {12'h0, r.gen_clk_en, r.gen_clk_rate};
            tcg_pkg::IDX_REF_SEL: reg_read = {12'h0, r.ref_en, r.ref_sel};
            tcg_pkg::IDX_REF_PIN: reg_read = {12'h0, r.ref_pin_oe, r.ref_pin_div};
            default: reg_read = 16'h0000;
        endcase
    endfunction

    function automatic tcg_pkg::tcg_regs_t reg_write(input tcg_pkg::tcg_regs_t r, input logic [15:0] idx,
                                                     input logic [7:0] d);
        reg_write = r;
        unique case (idx)
            tcg_pkg::IDX_BIT_CLK: reg_write.bit_clk_rate = d[1:0];
            tcg_pkg::IDX_FRAME_SYNC: reg_write.fs_rate = d[0];
            tcg_pkg::IDX_GEN_CLK: begin
                reg_write.gen_clk_en = d[tcg_pkg::EN_BIT];
                if (d[2:0] <= tcg_pkg::GEN_CLK_MAX) begin // [RULE13]
                    reg_write.gen_clk_rate = d[2:0];
                end
            end
            tcg_pkg::IDX_REF_SEL: begin
                reg_write.ref_en = d[tcg_pkg::EN_BIT];
                if (d[2:0] <= tcg_pkg::REF_SEL_MAX) begin // [RULE13]
                    reg_write.ref_sel = d[2:0];
                end
            end
            tcg_pkg::IDX_REF_PIN: begin
                reg_write.ref_pin_oe = d[tcg_pkg::EN_BIT];
                if (d[2:0] <= tcg_pkg::REF_DIV_MAX) begin // [RULE13]
                    reg_write.ref_pin_div = d[2:0];
                end
            end
            default: reg_write = r;
        endcase
    endfunction

    function automatic logic [8:0] ref_pin_divisor(input logic [2:0] code);
        unique case (code)
            3'h0: ref_pin_divisor = tcg_pkg::DIV_256;
            3'h1: ref_pin_divisor = tcg_pkg::DIV_192;
            3'h2: ref_pin_divisor = tcg_pkg::DIV_4;
            3'h3: ref_pin_divisor = tcg_pkg::DIV_3;
            default: ref_pin_divisor = tcg_pkg::DIV_1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and dividers
    // ------------------------------------------------------------
    tcg_pkg::tcg_state_t s_r;
    tcg_pkg::tcg_state_t s_nxt;
    logic [tcg_pkg::SYN_W-1:0] pin_level;
    logic [tcg_pkg::SYN_W-1:0] pin_rise;
    logic alt_192_tick;
    logic ext_256_tick;
    logic pin_64_tick;
    logic ref_div_level;
    logic pin_is_input;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_go;
    logic [15:0] wr_idx;
    logic [15:0] rd_idx;
    logic src_tick;

    tcg_sync u_sync (
        .i_clk(I_CLK_SYS),
        .i_pins({I_MASTER_SLAVE_STRAP, I_PCM_FRAME_SYNC, I_REFERENCE_PIN, I_EXTERNAL_SYNC_CLOCK_ALT,
                 I_EXTERNAL_SYNC_CLOCK}),
        .o_level(pin_level),
        .o_rise(pin_rise)
    );

    tcg_div u_div_alt_192 (
        .i_clk(I_CLK_SYS),
        .i_rst(I_SYS_RST),
        .i_tick(pin_rise[tcg_pkg::SYN_ALT]),
        .i_div(tcg_pkg::DIV_192),
        .o_tick(alt_192_tick),
        .o_level()
    );

    tcg_div u_div_ext_256 (
        .i_clk(I_CLK_SYS),
        .i_rst(I_SYS_RST),
        .i_tick(pin_rise[tcg_pkg::SYN_EXT]),
        .i_div(tcg_pkg::DIV_256),
        .o_tick(ext_256_tick),
        .o_level()
    );

    tcg_div u_div_pin_64 (
        .i_clk(I_CLK_SYS),
        .i_rst(I_SYS_RST),
        .i_tick(pin_rise[tcg_pkg::SYN_PIN] & pin_is_input),
        .i_div(tcg_pkg::DIV_64),
        .o_tick(pin_64_tick),
        .o_level()
    );

    tcg_div u_div_ref_pin (
        .i_clk(I_CLK_SYS),
        .i_rst(I_SYS_RST),
        .i_tick(pin_rise[tcg_pkg::SYN_EXT]),
        .i_div(ref_pin_divisor(s_r.regs.ref_pin_div)), // [RULE10]
        .o_tick(),
        .o_level(ref_div_level)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    assign pin_is_input = ~s_r.regs.ref_pin_oe;
    assign aw_fire = I_AXI_AWVALID & O_AXI_AWREADY;
    assign w_fire = I_AXI_WVALID & O_AXI_WREADY;
    assign ar_fire = I_AXI_ARVALID & O_AXI_ARREADY;
    assign wr_go = s_r.axi.aw_got & s_r.axi.w_got;
    assign wr_idx = word_index(s_r.axi.awaddr);
    assign rd_idx = word_index(I_AXI_ARADDR);

    always_comb begin
        unique case (s_r.regs.ref_sel) // [RULE8]
            tcg_pkg::SEL_ALT_192: src_tick = alt_192_tick;
            tcg_pkg::SEL_EXT_256: src_tick = ext_256_tick;
            tcg_pkg::SEL_EXT: src_tick = pin_rise[tcg_pkg::SYN_EXT];
            tcg_pkg::SEL_PIN: src_tick = pin_rise[tcg_pkg::SYN_PIN] & pin_is_input;
            tcg_pkg::SEL_PIN_64: src_tick = pin_64_tick;
            tcg_pkg::SEL_FS: src_tick = pin_rise[tcg_pkg::SYN_FS] & ~s_r.master;
            default: src_tick = 1'b0;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        if (aw_fire) begin
            s_nxt.axi.aw_got = 1'b1;
            s_nxt.axi.awaddr = I_AXI_AWADDR;
        end
        if (w_fire) begin
            s_nxt.axi.w_got = 1'b1;
            s_nxt.axi.wdata = I_AXI_WDATA;
            s_nxt.axi.wstrb = I_AXI_WSTRB;
        end
        if (s_r.axi.bvalid && I_AXI_BREADY) begin
            s_nxt.axi.bvalid = 1'b0;
        end
        if (wr_go) begin
            s_nxt.axi.aw_got = 1'b0;
            s_nxt.axi.w_got = 1'b0;
            s_nxt.axi.bvalid = 1'b1;
            s_nxt.axi.bresp = is_mapped(wr_idx) ? tcg_pkg::RESP_OKAY : tcg_pkg::RESP_SLVERR;
            if (s_r.axi.wstrb[0]) begin
                s_nxt.regs = reg_write(s_r.regs, wr_idx, s_r.axi.wdata[7:0]);
            end
        end
        if (s_r.axi.rvalid && I_AXI_RREADY) begin
            s_nxt.axi.rvalid = 1'b0;
        end
        if (ar_fire) begin
            s_nxt.axi.rvalid = 1'b1;
            s_nxt.axi.rdata = {16'h0000, reg_read(s_r.regs, rd_idx)}; // [RULE12]
            s_nxt.axi.rresp = is_mapped(rd_idx) ? tcg_pkg::RESP_OKAY : tcg_pkg::RESP_SLVERR;
        end
        s_nxt.ref_tick = s_r.regs.ref_en & src_tick; // [RULE7]
        if (s_r.regs.ref_pin_div == tcg_pkg::REF_DIV_1) begin
            s_nxt.ref_pin_out = s_r.regs.ref_pin_oe & pin_level[tcg_pkg::SYN_EXT]; // [RULE10]
        end else begin
            s_nxt.ref_pin_out = s_r.regs.ref_pin_oe & ref_div_level;
        end
        if (I_SYS_RST) begin
            s_nxt = '0;
            s_nxt.regs = tcg_pkg::REGS_RESET;
            s_nxt.master = pin_level[tcg_pkg::SYN_STRAP]; // [RULE4]
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        s_r <= s_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_AXI_AWREADY = ~s_r.axi.aw_got & ~s_r.axi.bvalid;
    assign O_AXI_WREADY = ~s_r.axi.w_got & ~s_r.axi.bvalid;
    assign O_AXI_BVALID = s_r.axi.bvalid;
    assign O_AXI_BRESP = s_r.axi.bresp;
    assign O_AXI_ARREADY = ~s_r.axi.rvalid;
    assign O_AXI_RVALID = s_r.axi.rvalid;
    assign O_AXI_RDATA = s_r.axi.rdata;
    assign O_AXI_RRESP = s_r.axi.rresp;
    assign O_PCM_BIT_CLOCK_OE = s_r.master; // [RULE4]
    assign O_PCM_FRAME_SYNC_OE = s_r.master;
    assign O_PCM_BIT_CLOCK_RATE = s_r.master ? s_r.regs.bit_clk_rate : 2'h0; // [RULE1]
    assign O_PCM_FRAME_SYNC_8K = s_r.master | s_r.regs.fs_rate; // [RULE2] [RULE3]
    assign O_GENERAL_CLOCK_OUTPUT_RATE = s_r.regs.gen_clk_rate; // [RULE6]
    assign O_GENERAL_CLOCK_OUTPUT_OE = s_r.regs.gen_clk_en; // [RULE5]
    assign O_OSC_REF_TICK = s_r.ref_tick;
    assign O_REFERENCE_PIN = s_r.ref_pin_out;
    assign O_REFERENCE_PIN_OE = s_r.regs.ref_pin_oe; // [RULE9]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);

    sequence s_gen_clk_write;
        wr_go && wr_idx == tcg_pkg::IDX_GEN_CLK && s_r.axi.wstrb[0];
    endsequence

    property p_gen_clk_oe;
        s_gen_clk_write |=> (O_GENERAL_CLOCK_OUTPUT_OE == $past(s_r.axi.wdata[3]));
    endproperty
    a_gen_clk_oe: assert property (p_gen_clk_oe) else $error("clock output enable not taken"); // [RULE5]

    property p_gen_clk_rate;
        (s_gen_clk_write ##0 s_r.axi.wdata[2:0] <= 3'h4)
            |=> (O_GENERAL_CLOCK_OUTPUT_RATE == $past(s_r.axi.wdata[2:0]));
    endproperty
    a_gen_clk_rate: assert property (p_gen_clk_rate) else $error("clock output rate not taken"); // [RULE6]

    property p_gen_clk_reserved;
        (s_gen_clk_write ##0 s_r.axi.wdata[2:0] > 3'h4) |=> $stable(O_GENERAL_CLOCK_OUTPUT_RATE);
    endproperty
    a_gen_clk_reserved: assert property (p_gen_clk_reserved) else $error("reserved rate code stored"); // [RULE13]

    property p_bit_clk_rate;
        !O_PCM_BIT_CLOCK_OE |-> O_PCM_BIT_CLOCK_RATE == 2'h0;
    endproperty
    a_bit_clk_rate: assert property (p_bit_clk_rate) else $error("bit clock rate set in slave mode"); // [RULE1]

    property p_fs_master;
        O_PCM_FRAME_SYNC_OE |-> O_PCM_FRAME_SYNC_8K;
    endproperty
    a_fs_master: assert property (p_fs_master) else $error("master frame sync not 8 kHz"); // [RULE2]

    property p_strap_held;
        $past(!I_SYS_RST) |-> $stable(O_PCM_BIT_CLOCK_OE) && O_PCM_BIT_CLOCK_OE == O_PCM_FRAME_SYNC_OE;
    endproperty
    a_strap_held: assert property (p_strap_held) else $error("pin direction changed after reset"); // [RULE4]

    property p_ref_disabled;
        !s_r.regs.ref_en |=> !O_OSC_REF_TICK;
    endproperty
    a_ref_disabled: assert property (p_ref_disabled) else $error("reference tick while disabled"); // [RULE7]

    property p_ref_direct;
        (s_r.regs.ref_en && s_r.regs.ref_sel == 3'h2 && pin_rise[0]) |=> O_OSC_REF_TICK;
    endproperty
    a_ref_direct: assert property (p_ref_direct) else $error("direct reference edge lost"); // [RULE8]

    property p_ref_pin_off;
        !O_REFERENCE_PIN_OE |=> !O_REFERENCE_PIN;
    endproperty
    a_ref_pin_off: assert property (p_ref_pin_off) else $error("reference pin driven while input"); // [RULE9]

    property p_read_zero;
        O_AXI_RVALID |-> O_AXI_RDATA[31:4] == 28'h0000000;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("unused bits read nonzero"); // [RULE12]

    property p_bvalid_hold;
        (O_AXI_BVALID && !I_AXI_BREADY) |=> O_AXI_BVALID;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped"); // [AXI4-Lite slave port]

endmodule

// *** sim/tcg_top_tb_top.sv ***
// Self-checking bench for the clock generator control block.
// Assumes tcg_pkg is compiled first; the bench drives AXI4-Lite and pins itself.
module tcg_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [17:0] awaddr = '0;
    logic [17:0] araddr = '0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [31:0] wdata = '0;
    logic strap = 1'h0;
    logic ext = 1'h0;
    logic [2:0] pins = '0;
    logic awready, wready, bvalid, arready, rvalid, oe_bc, oe_fs, fs8k, gen_oe, tick, refp, refp_oe;
    logic [1:0] bresp, rresp, bc_rate;
    logic [31:0] rdata;
    logic [2:0] gen_rate;
    int n_errors = 0;
    int tests_run = 0;
    logic [15:0] rv [5] = '{16'h0000, 16'h0001, 16'h0008, 16'h0000, 16'h0003};
    logic [15:0] ro [5] = '{16'h0003, 16'h0001, 16'h0008, 16'h0008, 16'h000b};

    always #20 clk = ~clk;

    tcg_top i_tcg_top (
        .I_CLK_SYS(clk), .I_SYS_RST(rst),
        .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
        .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hf), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
        .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
        .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
        .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
        .I_MASTER_SLAVE_STRAP(strap), .I_EXTERNAL_SYNC_CLOCK(ext), .I_EXTERNAL_SYNC_CLOCK_ALT(pins[0]),
        .I_REFERENCE_PIN(pins[1]), .I_PCM_FRAME_SYNC(pins[2]),
        .O_PCM_BIT_CLOCK_RATE(bc_rate), .O_PCM_BIT_CLOCK_OE(oe_bc), .O_PCM_FRAME_SYNC_OE(oe_fs),
        .O_PCM_FRAME_SYNC_8K(fs8k), .O_GENERAL_CLOCK_OUTPUT_RATE(gen_rate),
        .O_GENERAL_CLOCK_OUTPUT_OE(gen_oe), .O_OSC_REF_TICK(tick), .O_REFERENCE_PIN(refp),
        .O_REFERENCE_PIN_OE(refp_oe)
    );

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    function automatic logic [17:0] ad(input int i);
        return {tcg_pkg::IDX_BIT_CLK + 16'(i), 2'h0};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (tb) break;
        end
        bready <= 1'h0;
        @(posedge clk);
        chk(32'(r), 32'(er));
    endtask

    task automatic rd(input logic [17:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'h0;
            if (tr) break;
        end
        rready <= 1'h0;
        @(posedge clk);
        chk(d, ed);
        chk(32'(r), 32'(er));
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_mode(input logic m);
        strap <= m;
        rst <= 1'h1;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk(32'({oe_bc, oe_fs}), 32'({m, m}));
        wr(ad(0), 32'h2, tcg_pkg::RESP_OKAY);
        chk(32'(bc_rate), m ? 32'h2 : 32'h0);
        wr(ad(1), 32'h0, tcg_pkg::RESP_OKAY);
        chk(32'(fs8k), 32'(m));
        wr(ad(1), 32'h1, tcg_pkg::RESP_OKAY);
        chk(32'(fs8k), 32'h1);
    endtask

    task automatic t_regs;
        rst <= 1'h1;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        for (int i = 0; i < 5; i++) rd(ad(i), 32'(rv[i]), tcg_pkg::RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            wr(ad(i), 32'hffff_ffff, tcg_pkg::RESP_OKAY);
            rd(ad(i), 32'(ro[i]), tcg_pkg::RESP_OKAY);
        end
        wr(ad(5), 32'h1, tcg_pkg::RESP_SLVERR);
        rd(ad(5), 32'h0, tcg_pkg::RESP_SLVERR);
    endtask

    task automatic t_gen;
        for (int r = 0; r < 5; r++) begin
            wr(ad(2), 32'h8 | 32'(r), tcg_pkg::RESP_OKAY);
            chk(32'({gen_oe, gen_rate}), 32'h8 | 32'(r));
        end
        wr(ad(2), 32'h5, tcg_pkg::RESP_OKAY);
        chk(32'({gen_oe, gen_rate}), 32'h4);
    endtask

    // Pulses all pin clocks n times, 16-cycle period; counts ticks and reference pin rises
    task automatic ticks(input int n, input int exp, input int er);
        int c, e;
        logic hi, last;
        c = 0;
        e = 0;
        last = 1'h1;
        for (int k = 0; k < 16 * n + 8; k++) begin
            @(negedge clk);
            if (tick === 1'h1) c++;
            if (refp === 1'h1 && last !== 1'h1) e++;
            last = refp;
            @(posedge clk);
            hi = (k < 16 * n) && (k % 16 < 8);
            ext <= hi;
            pins <= {3{hi}};
        end
        chk(32'(c), 32'(exp));
        chk(32'(e), 32'(er));
    endtask

    task automatic t_ref;
        wr(ad(3), 32'ha, tcg_pkg::RESP_OKAY);
        wr(ad(4), 32'ha, tcg_pkg::RESP_OKAY);
        ticks(8, 8, 2);
        wr(ad(4), 32'hc, tcg_pkg::RESP_OKAY);
        chk(32'(refp_oe), 32'h1);
        ext <= 1'h1;
        repeat (6) @(posedge clk);
        chk(32'(refp), 32'h1);
        ext <= 1'h0;
        repeat (6) @(posedge clk);
        chk(32'(refp), 32'h0);
        wr(ad(4), 32'h4, tcg_pkg::RESP_OKAY);
        chk(32'({refp_oe, refp}), 32'h0);
        wr(ad(3), 32'h2, tcg_pkg::RESP_OKAY);
        ticks(1, 0, 0);
        wr(ad(3), 32'hb, tcg_pkg::RESP_OKAY);
        ticks(1, 1, 0);
        wr(ad(3), 32'hd, tcg_pkg::RESP_OKAY);
        ticks(1, 1, 0);
        wr(ad(3), 32'hc, tcg_pkg::RESP_OKAY);
        ticks(64, 1, 0);
        wr(ad(3), 32'h9, tcg_pkg::RESP_OKAY);
        ticks(256, 1, 0);
        wr(ad(3), 32'h8, tcg_pkg::RESP_OKAY);
        ticks(192, 1, 0);
    endtask

    task automatic summarize;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        t_mode(1'h0);
        t_regs;
        t_gen;
        t_ref;
        t_mode(1'h1);
        summarize;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize;
    end
endmodule
